// >>> include/arbiter_pkg.sv
// Shared types and constants for the hold request and refresh arbiter.
// Assumes a single system clock domain; pin inputs arrive asynchronously.
package arbiter_pkg;

  // Width of the upper address bits driven from the page mapper
  localparam int PAGE_WIDTH = 7;
  // Width of the continuously running timer counters
  localparam int CNT_WIDTH = 16;
  // Nominal rate of the timer tick pin, for reference only
  localparam int TIMER_TICK_HZ = 1190000;

  // Refresh strobe stays low for this many system clock rising edges
  localparam int REFRESH_LOW_EDGES = 4;
  // Channel ready is checked at this rising edge of the strobe
  localparam int REFRESH_CHECK_EDGE = 3;
  localparam logic [2:0] REF_LAST_CNT = 3'(REFRESH_LOW_EDGES - 1);
  localparam logic [2:0] REF_CHECK_CNT = 3'(REFRESH_CHECK_EDGE - 1);
  localparam logic [2:0] REF_CNT_START = 3'h0;
  localparam logic [2:0] REF_CNT_STEP = 3'h1;

  // Asynchronous pin inputs, carried together through the synchroniser
  typedef struct packed {
    logic arbiter_reset;
    logic timer_tick_input;
    logic channel_ready;
    logic refresh_strobe_n_in;
    logic bus_master_takeover_n;
    logic cpu_int_ack_n;
    logic periph_mem_write_n;
  } async_pins_t;

  localparam async_pins_t PINS_IDLE = '{
    arbiter_reset: 1'b0,
    timer_tick_input: 1'b0,
    channel_ready: 1'b1,
    refresh_strobe_n_in: 1'b1,
    bus_master_takeover_n: 1'b1,
    cpu_int_ack_n: 1'b1,
    periph_mem_write_n: 1'b1
  };

  typedef enum logic [2:0] {
    ARB_IDLE = 3'h0,
    ARB_DMA_WAIT = 3'h1,
    ARB_DMA_GRANT = 3'h3,
    ARB_REF_WAIT = 3'h2,
    ARB_REF_LOW = 3'h6,
    ARB_REF_STRETCH = 3'h7
  } arb_mode_t;

  typedef struct packed {
    async_pins_t sync1;
    async_pins_t sync2;
    arb_mode_t mode;
    logic dma_phase;
    logic dma_req;
    logic timer1_prev;
    logic tick_prev;
    logic refresh_n_prev;
    logic int_ack_prev;
    logic refresh_pending;
    logic enabled;
    logic [2:0] edge_cnt;
    logic cpu_req;
    logic dma_ack;
    logic strobe_oe;
    logic [PAGE_WIDTH-1:0] upper_addr;
  } arb_state_t;

  localparam arb_state_t ARB_RESET = '{
    sync1: PINS_IDLE,
    sync2: PINS_IDLE,
    mode: ARB_IDLE,
    dma_phase: 1'b0,
    dma_req: 1'b0,
    timer1_prev: 1'b1,
    tick_prev: 1'b0,
    refresh_n_prev: 1'b1,
    int_ack_prev: 1'b1,
    refresh_pending: 1'b0,
    enabled: 1'b1,
    edge_cnt: 3'h0,
    cpu_req: 1'b0,
    dma_ack: 1'b0,
    strobe_oe: 1'b0,
    upper_addr: 7'h00
  };

  typedef struct packed {
    logic [CNT_WIDTH-1:0] count;
    logic out;
  } counter_state_t;

  localparam counter_state_t COUNTER_RESET = '{
    count: 16'h0000,
    out: 1'b1
  };

endpackage

// >>> rtl/tick_counter.sv
// Free-running rate counter stepped by a one-cycle tick pulse.
// Assumes tick is already synchronous to clk_sys; reload should be >= 2.
`timescale 1ns/1ps
module tick_counter
  import arbiter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic gate,
  input wire logic [CNT_WIDTH-1:0] reload,
  output logic out
);

  counter_state_t r;
  counter_state_t next_r;

  always_comb
  begin
    next_r = r;
    if (tick && gate)
    begin
      // Output dips low for one tick per period, so it rises once a period
      if (r.count <= CNT_WIDTH'(1))
      begin
        next_r.count = reload;
        next_r.out = 1'b0;
      end
      else
      begin
        next_r.count = r.count - CNT_WIDTH'(1);
        next_r.out = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      r <= COUNTER_RESET;
    else
      r <= next_r;
  end

  assign out = r.out;

endmodule

// >>> rtl/hold_request_refresh_arbiter.sv
// Hold request arbiter between DMA controller 2 and periodic refresh.
// Assumes the DMA hold request and CPU bus grant are synchronous to
// clk_sys; all pins in the async bundle are synchronised here.
//
// Functional notes
// RULE_01: Requests come from DMA hold and timer 1.
// RULE_02: DMA sampled on rising, timer on falling phase.
// RULE_03: First captured request wins; other waits. (Code: in idle, DMA wins whenever both requests are pending.)
// RULE_04: Pending other source served without releasing bus.
// RULE_05: CPU request drops only when nobody requests.
// RULE_06: DMA grant waits for CPU bus grant.
// RULE_07: After DMA, refresh if pending, else release.
// RULE_08: Refresh waits for grant, then strobe low.
// RULE_09: Strobe low four edges, then released.
// RULE_10: DMA pending at fourth edge acknowledged next.
// RULE_11: Channel ready low at third edge stretches.
// RULE_12: Refresh pin is open drain, also input.
// RULE_13: Upper address driven only with grant, no takeover.
// RULE_14: Timers 0 and 1 always gated on.
// RULE_15: Refresh cycle drives refresh page address.
// RULE_16: DMA clock is system clock divided two.
// RULE_17: Active-high reset pin clears arbiter state.
// RULE_18: Memory write re-enables arbiter after int ack.
// RULE_19: Timer edge sets sticky pending refresh flag.
// RULE_20: Clocked state machine: idle, DMA, refresh.
`timescale 1ns/1ps
module hold_request_refresh_arbiter
  import arbiter_pkg::*;
#(
  parameter logic [CNT_WIDTH-1:0] TIMER0_RELOAD = 16'h0100,
  parameter logic [CNT_WIDTH-1:0] TIMER1_RELOAD = 16'h0012
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire async_pins_t pins,
  input wire logic dma_hold_request,
  input wire logic cpu_bus_grant,
  input wire logic [PAGE_WIDTH-1:0] dma_page,
  input wire logic [PAGE_WIDTH-1:0] refresh_page,
  output logic dma_hold_ack,
  output logic cpu_bus_request,
  output logic refresh_strobe_n_out,
  output logic refresh_strobe_n_oe,
  output logic refresh_active,
  output logic [PAGE_WIDTH-1:0] upper_addr_out,
  output logic upper_addr_oe,
  output logic dma_half_clock,
  output logic timer0_out,
  output logic timer1_out
);

  arb_state_t r;
  arb_state_t next_r;
  async_pins_t s;
  logic tick_event;

  assign s = r.sync2;
  assign tick_event = s.timer_tick_input && !r.tick_prev;

  tick_counter u_timer0
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(tick_event),
    .gate(1'b1), // RULE_14
    .reload(TIMER0_RELOAD),
    .out(timer0_out)
  );

  tick_counter u_timer1
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(tick_event),
    .gate(1'b1), // RULE_14
    .reload(TIMER1_RELOAD),
    .out(timer1_out)
  );

  always_comb
  begin
    logic timer_event;
    logic ext_event;
    logic finish;
    logic in_refresh;
    timer_event = 1'b0;
    ext_event = 1'b0;
    finish = 1'b0;
    in_refresh = 1'b0;
    next_r = r;

    // Two-stage synchroniser for every pin input
    next_r.sync1 = pins;
    next_r.sync2 = r.sync1;
    next_r.tick_prev = s.timer_tick_input;

    next_r.dma_phase = !r.dma_phase; // RULE_16

    // DMA request on the rising phase, timer on the falling phase
    if (!r.dma_phase)
      next_r.dma_req = dma_hold_request; // RULE_02
    else
    begin
      next_r.timer1_prev = timer1_out;
      timer_event = timer1_out && !r.timer1_prev; // RULE_01 RULE_02
    end

    in_refresh = (r.mode == ARB_REF_LOW) || (r.mode == ARB_REF_STRETCH);

    // Outside refresh, a low on the shared strobe pin starts a refresh
    next_r.refresh_n_prev = s.refresh_strobe_n_in;
    ext_event = !s.refresh_strobe_n_in && r.refresh_n_prev &&
                !in_refresh && !r.strobe_oe; // RULE_12

    // Interrupt acknowledge freezes new arbitration until memory write
    next_r.int_ack_prev = s.cpu_int_ack_n;
    if (!s.cpu_int_ack_n && r.int_ack_prev)
      next_r.enabled = 1'b0;
    if (!s.periph_mem_write_n)
      next_r.enabled = 1'b1; // RULE_18

    case (r.mode)
      ARB_IDLE:
      begin
        next_r.cpu_req = 1'b0; // RULE_05
        if (r.enabled && r.dma_req)
        begin
          next_r.mode = ARB_DMA_WAIT; // RULE_03
          next_r.cpu_req = 1'b1; // RULE_06
        end
        else if (r.enabled && r.refresh_pending)
        begin
          next_r.mode = ARB_REF_WAIT; // RULE_03
          next_r.cpu_req = 1'b1; // RULE_08
        end
      end
      ARB_DMA_WAIT:
      begin
        if (!r.dma_req)
        begin
          // Request withdrawn before the grant came back
          if (r.refresh_pending)
            next_r.mode = ARB_REF_WAIT;
          else
          begin
            next_r.mode = ARB_IDLE;
            next_r.cpu_req = 1'b0; // RULE_05
          end
        end
        else if (cpu_bus_grant)
        begin
          next_r.mode = ARB_DMA_GRANT;
          next_r.dma_ack = 1'b1; // RULE_06
        end
      end
      ARB_DMA_GRANT:
      begin
        if (!r.dma_req)
        begin
          next_r.dma_ack = 1'b0;
          if (r.refresh_pending)
            next_r.mode = ARB_REF_WAIT; // RULE_04 RULE_07
          else
          begin
            next_r.mode = ARB_IDLE;
            next_r.cpu_req = 1'b0; // RULE_05 RULE_07
          end
        end
      end
      ARB_REF_WAIT:
      begin
        if (cpu_bus_grant)
        begin
          next_r.mode = ARB_REF_LOW;
          next_r.strobe_oe = 1'b1; // RULE_08
          next_r.edge_cnt = REF_CNT_START;
        end
      end
      ARB_REF_LOW:
      begin
        next_r.edge_cnt = r.edge_cnt + REF_CNT_STEP;
        if (r.edge_cnt == REF_CHECK_CNT && !s.channel_ready)
          next_r.mode = ARB_REF_STRETCH; // RULE_11
        else if (r.edge_cnt == REF_LAST_CNT)
          finish = 1'b1; // RULE_09
      end
      ARB_REF_STRETCH:
      begin
        if (s.channel_ready)
          finish = 1'b1; // RULE_11
      end
      default:
      begin
        next_r.mode = ARB_IDLE;
        next_r.cpu_req = 1'b0;
        next_r.dma_ack = 1'b0;
        next_r.strobe_oe = 1'b0;
      end
    endcase

    if (finish)
    begin
      next_r.strobe_oe = 1'b0; // RULE_09
      next_r.refresh_pending = 1'b0;
      if (r.dma_req)
      begin
        // Bus is still granted, so the DMA side is served at once
        next_r.mode = ARB_DMA_GRANT; // RULE_10 RULE_04
        next_r.dma_ack = 1'b1;
      end
      else
      begin
        next_r.mode = ARB_IDLE;
        next_r.cpu_req = 1'b0; // RULE_09 RULE_05
      end
    end

    // A new request in the clearing cycle is kept
    if (timer_event || ext_event)
      next_r.refresh_pending = 1'b1; // RULE_19

    // Refresh page leads the upper address during any refresh
    if (next_r.strobe_oe || !s.refresh_strobe_n_in)
      next_r.upper_addr = refresh_page; // RULE_15
    else
      next_r.upper_addr = dma_page;

    if (s.arbiter_reset)
    begin
      next_r.mode = ARB_IDLE; // RULE_17
      next_r.dma_req = 1'b0;
      next_r.refresh_pending = 1'b0;
      next_r.enabled = 1'b1;
      next_r.edge_cnt = REF_CNT_START;
      next_r.cpu_req = 1'b0;
      next_r.dma_ack = 1'b0;
      next_r.strobe_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      r <= ARB_RESET;
    else
      r <= next_r; // RULE_20
  end

  assign dma_hold_ack = r.dma_ack;
  assign cpu_bus_request = r.cpu_req;
  // Open drain: only ever pulls low, the pull-up restores high
  assign refresh_strobe_n_out = 1'b0; // RULE_12
  assign refresh_strobe_n_oe = r.strobe_oe;
  assign refresh_active = r.strobe_oe || !s.refresh_strobe_n_in;
  assign upper_addr_out = r.upper_addr;
  assign upper_addr_oe = cpu_bus_grant && s.bus_master_takeover_n; // RULE_13
  assign dma_half_clock = r.dma_phase;

endmodule

// >>> test/arbiter_props.sv
// Port checks of the hold request and refresh arbiter.
// Assumes one clock domain; bound into every arbiter instance.
`timescale 1ns/1ps
module arbiter_props
  import arbiter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire async_pins_t pins,
  input wire logic dma_hold_request,
  input wire logic cpu_bus_grant,
  input wire logic [PAGE_WIDTH-1:0] refresh_page,
  input wire logic dma_hold_ack,
  input wire logic cpu_bus_request,
  input wire logic refresh_strobe_n_oe,
  input wire logic [PAGE_WIDTH-1:0] upper_addr_out,
  input wire logic upper_addr_oe,
  input wire logic dma_half_clock
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  a_half_clock:
  assert property ($past(arst_n) |-> dma_half_clock != $past(dma_half_clock))
    else $error("half clock stuck");
  a_ack_after_grant:
  assert property ($rose(dma_hold_ack) |-> $past(cpu_bus_grant) &&
    cpu_bus_request) else $error("ack without grant");
  a_ack_exclusive:
  assert property (dma_hold_ack |-> cpu_bus_request && !refresh_strobe_n_oe)
    else $error("ack overlaps refresh");
  a_ack_drop:
  assert property (!dma_hold_request[*3] |=> !dma_hold_ack)
    else $error("ack outlived request");
  a_strobe_grant:
  assert property ($rose(refresh_strobe_n_oe) |-> $past(cpu_bus_grant) &&
    cpu_bus_request) else $error("strobe without grant");
  a_strobe_width:
  assert property ($rose(refresh_strobe_n_oe) && pins.channel_ready ##1
    pins.channel_ready[*3] |=> !refresh_strobe_n_oe)
    else $error("strobe too long");
  a_strobe_min:
  assert property ($rose(refresh_strobe_n_oe) |-> refresh_strobe_n_oe[*4])
    else $error("strobe too short");
  a_addr_enable:
  assert property (upper_addr_oe == (cpu_bus_grant &&
    $past(pins.bus_master_takeover_n, 2))) else $error("address enable");
  a_refresh_page:
  assert property ($past(refresh_strobe_n_oe) && refresh_strobe_n_oe |->
    upper_addr_out == refresh_page) else $error("refresh page");
  c_refresh: cover property ($rose(refresh_strobe_n_oe));
  c_dma: cover property ($rose(dma_hold_ack));
  c_stretch: cover property (refresh_strobe_n_oe[*6]);
endmodule
bind hold_request_refresh_arbiter arbiter_props i_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .pins(pins),
  .dma_hold_request(dma_hold_request), .cpu_bus_grant(cpu_bus_grant),
  .refresh_page(refresh_page), .dma_hold_ack(dma_hold_ack),
  .cpu_bus_request(cpu_bus_request),
  .refresh_strobe_n_oe(refresh_strobe_n_oe),
  .upper_addr_out(upper_addr_out), .upper_addr_oe(upper_addr_oe),
  .dma_half_clock(dma_half_clock));

// >>> test/bus_partner.sv
// Far side model: CPU hold handshake and DMA hold requester.
// Assumes go is a one-cycle pulse given while the DMA side is idle.
`timescale 1ns/1ps
module bus_partner (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cpu_bus_request,
  input wire logic dma_hold_ack,
  input wire logic go,
  input wire logic [3:0] lag,
  input wire logic [5:0] len,
  output logic cpu_bus_grant,
  output logic dma_hold_request
);
  logic [3:0] waited;
  logic [5:0] left;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_bus_grant <= 1'b0;
      dma_hold_request <= 1'b0;
      waited <= 4'h0;
      left <= 6'h00;
    end
    else
    begin
      // CPU grants after a lag and lets go as soon as the request does
      if (!cpu_bus_request)
        waited <= 4'h0;
      else if (waited != lag)
        waited <= waited + 4'h1;
      cpu_bus_grant <= cpu_bus_request && waited == lag;
      if (go)
      begin
        dma_hold_request <= 1'b1;
        left <= len;
      end
      else if (dma_hold_ack && dma_hold_request)
      begin
        left <= left - 6'h01;
        if (left == 6'h00)
          dma_hold_request <= 1'b0;
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the hold request and refresh arbiter.
// Assumes bus_partner answers for the CPU and the DMA controller.
`timescale 1ns/1ps
module tb_top;
  import arbiter_pkg::*;
  localparam int HOLD = 8;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic ext_n = 1'b1;
  logic go = 1'b0;
  logic skip = 1'b0;
  logic t1_q = 1'b1;
  logic ack_q = 1'b0;
  logic [3:0] lag = 4'h8;
  logic [5:0] len = 6'h01;
  logic [PAGE_WIDTH-1:0] page = 7'h15;
  logic [PAGE_WIDTH-1:0] addr;
  logic grant, dreq, ack, req, s_oe, a_oe, t1;
  logic act, t0;
  logic t0_q = 1'b1;
  int n_t0 = 0;
  async_pins_t drv = PINS_IDLE;
  async_pins_t pins;
  int n_fail = 0, compares = 0, seed = 32'h738a48ba;
  int n_tick = 0, n_ref = 0, n_go = 0, n_ack = 0, n_ext = 0;
  int run = 0, last = 0, w;
  always #50 clk_sys = ~clk_sys;
  always_comb
  begin
    pins = drv;
    pins.refresh_strobe_n_in = ext_n & ~s_oe;
  end
  always
  begin
    repeat (4) @(negedge clk_sys);
    drv.timer_tick_input = ~drv.timer_tick_input;
  end
  hold_request_refresh_arbiter #(.TIMER0_RELOAD(16'h0002),
    .TIMER1_RELOAD(16'h0010)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .pins(pins), .dma_hold_request(dreq), .cpu_bus_grant(grant),
    .dma_page(page), .refresh_page(7'h6a), .dma_hold_ack(ack),
    .cpu_bus_request(req), .refresh_strobe_n_out(),
    .refresh_strobe_n_oe(s_oe), .refresh_active(act),
    .upper_addr_out(addr),
    .upper_addr_oe(a_oe), .dma_half_clock(), .timer0_out(t0),
    .timer1_out(t1));
  bus_partner i_partner (.clk_sys(clk_sys), .arst_n(arst_n),
    .cpu_bus_request(req), .dma_hold_ack(ack), .go(go), .lag(lag),
    .len(len), .cpu_bus_grant(grant), .dma_hold_request(dreq));
  function automatic logic ref_ok(int got, int want);
    return got <= want && got + 3 >= want;
  endfunction
  function automatic logic stretch_ok(int n);
    return n >= HOLD + 2 && n <= HOLD + 5;
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle;
    for (w = 0; w < 400 && (req || dreq || ack); w++)
      @(negedge clk_sys);
    if (req || dreq || ack)
      n_fail++;
  endtask
  task automatic burst(input logic [5:0] n);
    idle();
    page = 7'($random(seed));
    len = n;
    go = 1'b1;
    n_go++;
    @(negedge clk_sys);
    go = 1'b0;
  endtask
  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk_sys)
  begin
    if (t1 && !t1_q)
      n_tick++;
    if (ack && !ack_q)
      n_ack++;
    if (t0 && !t0_q)
      n_t0++;
    t1_q = t1;
    ack_q = ack;
    t0_q = t0;
    if (s_oe)
      check("refresh active", act, 8'h01);
    if (s_oe)
      run++;
    else if (run != 0)
    begin
      n_ref++;
      if (!skip)
        check("strobe length", 8'(run), 8'h04);
      else if (last == 0)
        last = run;
      run = 0;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    check("reset request", {ack, req, s_oe}, 8'h00);
    check("reset timer", t1, 8'h01);
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (30)
    begin
      repeat ($random(seed) & 63) @(negedge clk_sys);
      lag = 4'($random(seed));
      burst(6'($random(seed)));
    end
    $display("random traffic done");
    burst(6'h3f);
    for (w = 0; w < 300 && !ack; w++)
      @(negedge clk_sys);
    if (!ack)
      n_fail++;
    check("dma page", {1'b0, addr}, {1'b0, page});
    drv.bus_master_takeover_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("takeover float", a_oe, 8'h00);
    drv.bus_master_takeover_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("address drive", a_oe, 8'h01);
    drv.arbiter_reset = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("pin reset", {req, ack}, 8'h00);
    drv.arbiter_reset = 1'b0;
    $display("takeover and pin reset done");
    @(negedge s_oe);
    idle();
    lag = 4'h8;
    drv.cpu_int_ack_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    drv.cpu_int_ack_n = 1'b1;
    burst(6'h02);
    repeat (20) @(negedge clk_sys);
    check("disabled", req, 8'h00);
    drv.periph_mem_write_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    drv.periph_mem_write_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("enabled", req, 8'h01);
    $display("disable and enable done");
    idle();
    ext_n = 1'b0;
    n_ext++;
    repeat (3) @(negedge clk_sys);
    ext_n = 1'b1;
    $display("external refresh done");
    @(posedge s_oe);
    @(negedge clk_sys);
    last = 0;
    skip = 1'b1;
    drv.channel_ready = 1'b0;
    repeat (HOLD) @(negedge clk_sys);
    drv.channel_ready = 1'b1;
    repeat (20) @(negedge clk_sys);
    check("stretch", stretch_ok(last), 8'h01);
    skip = 1'b0;
    $display("stretch done");
    idle();
    check("dma grants", 8'(n_ack), 8'(n_go + 1));
    check("refreshes", ref_ok(n_ref, n_tick + n_ext), 8'h01);
    check("timer0 rate", 8'(n_t0 + 8 >= 8 * n_tick &&
      n_t0 <= 8 * n_tick + 8), 8'h01);
    print_verdict();
  end
  initial
  begin
    #3000000;
    n_fail++;
    print_verdict();
  end
endmodule
